// >>> core/fpc_device.sv
// Device end: power states, identity and signature output, write gating.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Only deep-sleep command enters sleep; sleep blocks writes.
// - Deselect gives standby only when no cycle runs.
// - In sleep only wake-signature is obeyed.
// - Power loss clears sleep; power-up lands in standby.
// - Deep-sleep needs exactly eight bits before deselect.
// - Sleep begins after the sleep entry delay.
// - Deep-sleep during busy cycle is rejected.
// - Read-identity shifts out 32 identity bits.
// - Read-identity ignored during program or erase.
// - Host may end identity output early.
// - Wake-signature returns signature whenever not busy.
// - Wake-signature ignored during any busy cycle.
// - Code, three dummy bytes, then signature out.
// - Further clocks repeat the signature.
// - Wake after full read takes read-wake delay.
// - Early deselect from sleep takes short wake delay.
// - Logic held in reset below threshold.
// - Write commands ignored during write-inhibit delay.
// - Host sends no writes before both delays.
// - Host may read after select delay.
// - Power-up clears latch, comes up in standby.
// - Status reads zero as delivered.
// - Busy flag set during program or erase.
module fpc_device #(
  parameter int SLEEP_ENTRY_CYC = fpc_pkg::SLEEP_ENTRY_CYC,
  parameter int WAKE_SHORT_CYC = fpc_pkg::WAKE_SHORT_CYC,
  parameter int WAKE_READ_CYC = fpc_pkg::WAKE_READ_CYC,
  parameter int WRITE_INHIBIT_CYC = fpc_pkg::WRITE_INHIBIT_CYC
) (
  fpc_link_if.device link,
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic boot_top_i,
  input wire logic prog_erase_busy_i,
  input wire logic status_write_busy_i,
  output logic deep_sleep_o,
  output logic standby_o,
  output logic write_inhibit_o,
  output logic write_enable_latch_o,
  output logic [7:0] status_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o
);
  localparam int DW = fpc_pkg::DELAY_W;
  localparam int IW = $clog2(WRITE_INHIBIT_CYC + 1);
  localparam int CW = fpc_pkg::CNT_W;

  // ==========================================================================
  // Link clock domain: frame capture
  logic started_reg, started_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [7:0] code_reg, code_next;
  logic miso_reg, miso_next;
  logic oe_n_reg, oe_n_next;
  logic [3:0] gate_s;
  logic [31:0] id_word;
  logic [CW-1:0] id_idx;
  logic awake_reg, awake_next;
  logic any_busy;

  assign any_busy = prog_erase_busy_i || status_write_busy_i;

  // The gate levels are stale for the first few edges of a frame, because the
  // link clock stands still between frames; they settle before the code byte ends.
  fpc_sync #(.WIDTH(4), .INIT(4'h0)) u_gate_sync (
    .clock_i(link.sclk),
    .rst_n_i(rst_n_i),
    .d_i({boot_top_i, awake_reg, prog_erase_busy_i, any_busy}),
    .q_o(gate_s)
  );

  // Bottom or top boot configuration shows in the capacity byte.
  assign id_word = {fpc_pkg::ID_CONTINUATION, fpc_pkg::ID_MAKER, fpc_pkg::ID_MEM_TYPE,
                    gate_s[3] ? fpc_pkg::ID_CAP_TOP : fpc_pkg::ID_CAP_BOTTOM};
  assign id_idx = fpc_pkg::ID_LAST - cnt_reg;

  always_comb begin
    started_next = 1'h1;
    if (!started_reg) begin
      cnt_next = {{(CW-1){1'h0}}, 1'h1};
      code_next = {7'h00, link.mosi};
    end else begin
      // Wrapping onto a multiple of eight keeps the signature phase intact.
      cnt_next = (cnt_reg == fpc_pkg::CNT_TOP) ? fpc_pkg::CNT_WRAP : CW'(cnt_reg + 1'h1);
      code_next = (cnt_reg < fpc_pkg::CMD_BITS) ? {code_reg[6:0], link.mosi} : code_reg;
    end
  end

  // A raised select restarts the next frame's count.
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      started_reg <= 1'h0;
    end else begin
      started_reg <= started_next;
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      code_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
      code_reg <= code_next;
    end
  end

  always_comb begin
    miso_next = 1'h0;
    oe_n_next = 1'h1;
    if (code_reg == fpc_pkg::CMD_READ_IDENTITY && cnt_reg >= fpc_pkg::CMD_BITS &&
        cnt_reg < fpc_pkg::FRAME_BITS && gate_s[2] && !gate_s[1]) begin
      miso_next = id_word[id_idx[4:0]];
      oe_n_next = 1'h0;
    end else if (code_reg == fpc_pkg::CMD_WAKE_SIGNATURE && cnt_reg >= fpc_pkg::SIG_START &&
                 !gate_s[0]) begin
      miso_next = fpc_pkg::SIGNATURE[3'(fpc_pkg::SIG_MSB - cnt_reg[2:0])];
      oe_n_next = 1'h0;
    end
  end

  always_ff @(negedge link.sclk or posedge link.cs_n or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_reg <= 1'h0;
      oe_n_reg <= 1'h1;
    end else if (link.cs_n) begin
      miso_reg <= 1'h0;
      oe_n_reg <= 1'h1;
    end else begin
      miso_reg <= miso_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign link.miso = miso_reg;
  assign link.miso_oe_n = oe_n_reg;

  // ==========================================================================
  // System clock domain: power state and write gating
  logic cs_s;
  logic [CW+7:0] sum_s;
  logic [CW-1:0] len_s;
  logic [7:0] code_s;
  logic cs_q_reg, cs_q_next;
  logic deselect;
  fpc_pkg::fpc_pwr_t state_reg, state_next;
  logic [DW-1:0] dcnt_reg, dcnt_next;
  logic [IW-1:0] inhibit_reg, inhibit_next;
  logic wel_reg, wel_next;
  logic cmd_valid_reg, cmd_valid_next;
  logic [7:0] cmd_code_reg, cmd_code_next;
  logic standby_reg, standby_next;
  logic sleep_reg, sleep_next;
  logic [7:0] status_reg, status_next;
  logic write_ok;
  logic is_cycle_cmd;

  fpc_sync #(.WIDTH(1), .INIT(1'h1)) u_cs_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(link.cs_n),
    .q_o(cs_s)
  );

  // Count and code are frozen while select is high, so they are settled by the
  // time the deselect edge comes out of its own synchroniser.
  fpc_sync #(.WIDTH(CW + 8)) u_sum_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i({cnt_reg, code_reg}),
    .q_o(sum_s)
  );

  assign len_s = sum_s[CW+7:8];
  assign code_s = sum_s[7:0];
  assign deselect = cs_s && !cs_q_reg;
  assign write_ok = deselect && state_reg == fpc_pkg::PWR_STANDBY && inhibit_reg == '0 &&
                    !any_busy && len_s >= fpc_pkg::CMD_BITS;
  assign is_cycle_cmd = code_s == fpc_pkg::CMD_PAGE_WRITE || code_s == fpc_pkg::CMD_BLOCK_CLEAR ||
                        code_s == fpc_pkg::CMD_ARRAY_CLEAR || code_s == fpc_pkg::CMD_STATUS_WRITE;

  always_comb begin
    cs_q_next = cs_s;
    state_next = state_reg;
    dcnt_next = (dcnt_reg == '0) ? dcnt_reg : DW'(dcnt_reg - 1'h1);
    inhibit_next = (inhibit_reg == '0) ? inhibit_reg : IW'(inhibit_reg - 1'h1);
    wel_next = wel_reg;
    cmd_valid_next = 1'h0;
    cmd_code_next = cmd_code_reg;
    unique case (state_reg)
      fpc_pkg::PWR_STANDBY: begin
        if (deselect && code_s == fpc_pkg::CMD_DEEP_SLEEP && len_s == fpc_pkg::CMD_BITS && !any_busy) begin
          state_next = fpc_pkg::PWR_ENTERING;
          dcnt_next = DW'(SLEEP_ENTRY_CYC - 1);
        end
      end
      fpc_pkg::PWR_ENTERING: begin
        if (dcnt_reg == '0) begin
          state_next = fpc_pkg::PWR_SLEEP;
        end
      end
      fpc_pkg::PWR_SLEEP: begin
        if (deselect && code_s == fpc_pkg::CMD_WAKE_SIGNATURE && len_s >= fpc_pkg::CMD_BITS && !any_busy) begin
          state_next = fpc_pkg::PWR_WAKING;
          if (len_s >= fpc_pkg::FRAME_BITS) begin
            dcnt_next = DW'(WAKE_READ_CYC - 1);
          end else begin
            dcnt_next = DW'(WAKE_SHORT_CYC - 1);
          end
        end
      end
      fpc_pkg::PWR_WAKING: begin
        if (dcnt_reg == '0) begin
          state_next = fpc_pkg::PWR_STANDBY;
        end
      end
    endcase
    if (write_ok && code_s == fpc_pkg::CMD_WRITE_UNLOCK && len_s == fpc_pkg::CMD_BITS) begin
      wel_next = 1'h1;
    end else if (write_ok && is_cycle_cmd && wel_reg) begin
      // The latch is handed over with the command to the cycle logic.
      cmd_valid_next = 1'h1;
      cmd_code_next = code_s;
      wel_next = 1'h0;
    end
    awake_next = state_next == fpc_pkg::PWR_STANDBY;
    standby_next = state_reg == fpc_pkg::PWR_STANDBY && cs_s && !any_busy;
    sleep_next = state_reg == fpc_pkg::PWR_SLEEP || state_reg == fpc_pkg::PWR_WAKING;
    status_next = fpc_pkg::STATUS_RESET;
    status_next[fpc_pkg::STATUS_BUSY_BIT] = any_busy;
    status_next[fpc_pkg::STATUS_WEL_BIT] = wel_reg;
  end

  // Reset stands for the power-on reset; it puts the device in standby.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_q_reg <= 1'h1;
      state_reg <= fpc_pkg::PWR_STANDBY;
      dcnt_reg <= '0;
      inhibit_reg <= IW'(WRITE_INHIBIT_CYC);
      wel_reg <= 1'h0;
      cmd_valid_reg <= 1'h0;
      cmd_code_reg <= 8'h00;
      awake_reg <= 1'h1;
      standby_reg <= 1'h0;
      sleep_reg <= 1'h0;
      status_reg <= fpc_pkg::STATUS_RESET;
    end else begin
      cs_q_reg <= cs_q_next;
      state_reg <= state_next;
      dcnt_reg <= dcnt_next;
      inhibit_reg <= inhibit_next;
      wel_reg <= wel_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_code_reg <= cmd_code_next;
      awake_reg <= awake_next;
      standby_reg <= standby_next;
      sleep_reg <= sleep_next;
      status_reg <= status_next;
    end
  end

  logic inhibit_out_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inhibit_out_reg <= 1'h1;
    end else begin
      inhibit_out_reg <= inhibit_next != '0;
    end
  end

  assign deep_sleep_o = sleep_reg;
  assign standby_o = standby_reg;
  assign write_inhibit_o = inhibit_out_reg;
  assign write_enable_latch_o = wel_reg;
  assign status_o = status_reg;
  assign cmd_valid_o = cmd_valid_reg;
  assign cmd_code_o = cmd_code_reg;
endmodule
`default_nettype wire

// >>> core/fpc_pkg.sv
// Shared constants and types for the flash power and identity control ends.
package fpc_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int WAKE_DELAY_SHORT_NS = 3000;
  localparam int WAKE_DELAY_AFTER_READ_NS = 1800;
  localparam int WRITE_INHIBIT_DELAY_NS = 1000000;
  localparam int SELECT_AFTER_SUPPLY_DELAY_NS = 100000;
  // Least times round up to whole cycles.
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_SHORT_CYC = (WAKE_DELAY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_READ_CYC = (WAKE_DELAY_AFTER_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_INHIBIT_CYC = (WRITE_INHIBIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_CYC = (SELECT_AFTER_SUPPLY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 6;
  localparam int GAP_MARGIN_CYC = 8;
  localparam int HOST_GAP_CYC = SLEEP_ENTRY_CYC + GAP_MARGIN_CYC;
  localparam int DELAY_W = 16;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] CMD_READ_IDENTITY = 8'h9F;
  localparam logic [7:0] CMD_WAKE_SIGNATURE = 8'hAB;
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_BLOCK_CLEAR = 8'hD8;
  localparam logic [7:0] CMD_ARRAY_CLEAR = 8'hC7;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;

  // ==========================================================================
  // Identity values; all of them are arbitrary.
  localparam logic [7:0] ID_CONTINUATION = 8'hA1;
  localparam logic [7:0] ID_MAKER = 8'hB2;
  localparam logic [7:0] ID_MEM_TYPE = 8'hC3;
  localparam logic [7:0] ID_CAP_BOTTOM = 8'hD4;
  localparam logic [7:0] ID_CAP_TOP = 8'hE5;
  localparam logic [7:0] SIGNATURE = 8'h5A;

  // ==========================================================================
  // Frame bit positions
  localparam int CNT_W = 6;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ID_LAST = 6'h27;
  localparam logic [5:0] FRAME_BITS = 6'h28;
  localparam logic [5:0] SIG_START = 6'h20;
  localparam logic [5:0] CNT_TOP = 6'h3F;
  localparam logic [5:0] CNT_WRAP = 6'h38;
  localparam logic [2:0] SIG_MSB = 3'h7;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum logic [1:0] {PWR_STANDBY, PWR_ENTERING, PWR_SLEEP, PWR_WAKING} fpc_pwr_t;
  typedef enum logic [1:0] {OP_DEEP_SLEEP, OP_READ_ID, OP_WAKE_SIG} fpc_op_t;
  typedef enum logic [2:0] {H_POWERUP, H_IDLE, H_LOW, H_HIGH, H_LAST, H_GAP} fpc_host_st_t;
endpackage

// >>> core/fpc_link_if.sv
// Serial link between the host controller and the flash control device.
`timescale 1ns/10ps
`default_nettype none
interface fpc_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;

  // The output line idles high through a pull-up while nobody drives it.
  assign miso_line = miso_oe_n ? 1'h1 : miso;

  modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe_n);
  modport host (output cs_n, output sclk, output mosi, input miso_line);
endinterface
`default_nettype wire

// >>> core/fpc_sync.sv
// Three-stage synchroniser whose output follows once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module fpc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;

  always_comb begin
    q_next = (s2_reg == s3_reg) ? s2_reg : q_reg;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_reg <= INIT;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

// >>> core/fpc_host.sv
// Host end: makes the link clock and runs deep-sleep, identity and signature frames.
`timescale 1ns/10ps
`default_nettype none
module fpc_host #(
  parameter int SCLK_HALF_CYC = fpc_pkg::SCLK_HALF_CYC,
  parameter int SELECT_CYC = fpc_pkg::SELECT_CYC,
  parameter int GAP_CYC = fpc_pkg::HOST_GAP_CYC
) (
  fpc_link_if.host link,
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire fpc_pkg::fpc_op_t req_op_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [31:0] rsp_data_o
);
  localparam int DW = fpc_pkg::DELAY_W;
  localparam int CW = fpc_pkg::CNT_W;

  // ==========================================================================
  // Frame sequencer
  fpc_pkg::fpc_host_st_t st_reg, st_next;
  logic [DW-1:0] tmr_reg, tmr_next;
  logic [CW-1:0] left_reg, left_next;
  logic [39:0] tx_reg, tx_next;
  logic [31:0] rx_reg, rx_next;
  logic sclk_reg, sclk_next, cs_n_reg, cs_n_next, mosi_reg, mosi_next;
  logic ready_reg, ready_next, rsp_valid_reg, rsp_valid_next;
  logic [31:0] rsp_data_reg, rsp_data_next;
  logic miso_s;
  logic [7:0] code;

  // The half period must exceed the synchroniser delay so that sampling just
  // before each rising edge sees the bit the device set at the falling edge.
  fpc_sync #(.WIDTH(1), .INIT(1'h1)) u_miso_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(link.miso_line),
    .q_o(miso_s)
  );

  always_comb begin
    unique case (req_op_i)
      fpc_pkg::OP_DEEP_SLEEP: code = fpc_pkg::CMD_DEEP_SLEEP;
      fpc_pkg::OP_READ_ID: code = fpc_pkg::CMD_READ_IDENTITY;
      default: code = fpc_pkg::CMD_WAKE_SIGNATURE;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    tmr_next = (tmr_reg == '0) ? tmr_reg : DW'(tmr_reg - 1'h1);
    left_next = left_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    mosi_next = mosi_reg;
    ready_next = 1'h0;
    rsp_valid_next = 1'h0;
    rsp_data_next = rsp_data_reg;
    unique case (st_reg)
      fpc_pkg::H_POWERUP: begin
        if (tmr_reg == '0) begin
          st_next = fpc_pkg::H_IDLE;
          ready_next = 1'h1;
        end
      end
      fpc_pkg::H_IDLE: begin
        ready_next = 1'h1;
        if (req_valid_i && ready_reg) begin
          ready_next = 1'h0;
          st_next = fpc_pkg::H_LOW;
          tx_next = {code, 32'h0000_0000};
          mosi_next = code[7];
          cs_n_next = 1'h0;
          tmr_next = DW'(SCLK_HALF_CYC - 1);
          // Deep-sleep stops at exactly eight bits; the others read one full unit.
          left_next = (req_op_i == fpc_pkg::OP_DEEP_SLEEP) ? fpc_pkg::CMD_BITS : fpc_pkg::FRAME_BITS;
        end
      end
      fpc_pkg::H_LOW: begin
        if (tmr_reg == '0) begin
          st_next = fpc_pkg::H_HIGH;
          sclk_next = 1'h1;
          rx_next = {rx_reg[30:0], miso_s};
          left_next = CW'(left_reg - 1'h1);
          tmr_next = DW'(SCLK_HALF_CYC - 1);
        end
      end
      fpc_pkg::H_HIGH: begin
        if (tmr_reg == '0) begin
          sclk_next = 1'h0;
          tx_next = {tx_reg[38:0], 1'h0};
          mosi_next = tx_reg[38];
          tmr_next = DW'(SCLK_HALF_CYC - 1);
          st_next = (left_reg == '0) ? fpc_pkg::H_LAST : fpc_pkg::H_LOW;
        end
      end
      fpc_pkg::H_LAST: begin
        if (tmr_reg == '0) begin
          st_next = fpc_pkg::H_GAP;
          cs_n_next = 1'h1;
          rsp_valid_next = 1'h1;
          rsp_data_next = rx_reg;
          tmr_next = DW'(GAP_CYC - 1);
        end
      end
      fpc_pkg::H_GAP: begin
        if (tmr_reg == '0) begin
          st_next = fpc_pkg::H_IDLE;
          ready_next = 1'h1;
        end
      end
      default: begin
        st_next = fpc_pkg::H_IDLE;
      end
    endcase
  end

  // The select delay after supply runs out of reset before the first frame.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= fpc_pkg::H_POWERUP;
      tmr_reg <= DW'(SELECT_CYC - 1);
      left_reg <= '0;
      tx_reg <= 40'h00_0000_0000;
      rx_reg <= 32'h0000_0000;
      sclk_reg <= 1'h0;
      cs_n_reg <= 1'h1;
      mosi_reg <= 1'h0;
      ready_reg <= 1'h0;
      rsp_valid_reg <= 1'h0;
      rsp_data_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      left_reg <= left_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      mosi_reg <= mosi_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = mosi_reg;
  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o = rsp_data_reg;
endmodule
`default_nettype wire

// >>> verif/fpc_props.sv
// Checker for the serial link between host and device.
`timescale 1ns/10ps
`default_nettype none
module fpc_props (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_line
);
  // ==========
  // Frame tracking
  localparam int GAP_MIN = 60;
  logic rise;
  logic sclk_reg, sclk_next;
  logic [5:0] rise_reg, rise_next;
  logic [7:0] code_reg, code_next, hi_reg, hi_next;
  always_comb begin
    rise = sclk && !sclk_reg;
    sclk_next = sclk;
    rise_next = cs_n ? 6'h00 : rise_reg + {5'h00, rise};
    code_next = (rise && rise_reg < fpc_pkg::CMD_BITS) ? {code_reg[6:0], mosi} : code_reg;
    hi_next = !cs_n ? 8'h00 : ((hi_reg == 8'hFF) ? hi_reg : hi_reg + 8'h01);
  end
  // The idle count starts full so the first frame after reset is not held to a wake gap.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_reg <= 1'h0;
      rise_reg <= 6'h00;
      code_reg <= 8'h00;
      hi_reg <= 8'hFF;
    end else begin
      sclk_reg <= sclk_next;
      rise_reg <= rise_next;
      code_reg <= code_next;
      hi_reg <= hi_next;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_high_phase;
    sclk [*6] ##1 !sclk;
  endsequence
  sequence s_last_fall;
    $past(sclk, 7) && !$past(sclk);
  endsequence
  a_sclk_half: assert property ($rose(sclk) |-> s_high_phase) else $error("bad clock high phase");
  a_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk) else $error("clock runs while idle");
  a_mosi_hold: assert property (sclk |-> $stable(mosi)) else $error("input data moved");
  a_miso_hold: assert property (sclk && $past(sclk) && !miso_oe_n |-> $stable(miso))
    else $error("output moved");
  a_cs_end: assert property ($rose(cs_n) |-> s_last_fall) else $error("deselect off bit boundary");
  a_frame_len: assert property ($rose(cs_n) |->
    rise_reg == fpc_pkg::CMD_BITS || rise_reg == fpc_pkg::FRAME_BITS) else $error("bad frame length");
  a_gap_hold: assert property ($fell(cs_n) |-> hi_reg >= GAP_MIN) else $error("deselect too short");
  a_desel_release: assert property (cs_n && $past(cs_n) |-> miso_oe_n && miso_line)
    else $error("driven idle");
  a_early_drive: assert property (!miso_oe_n |-> rise_reg >= fpc_pkg::CMD_BITS) else $error("driven early");
  a_sig_after_dummy: assert property (!miso_oe_n && code_reg == fpc_pkg::CMD_WAKE_SIGNATURE
    |-> rise_reg >= fpc_pkg::SIG_START) else $error("signature before dummies");
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Bench joining the host and device ends over the link.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ==========
  // Harness
  localparam int INHIBIT = 20;
  logic clock_i = 1'h0;
  // Reset is lowered just after time zero, so every asynchronous reset branch sees a real edge.
  logic rst_n_i = 1'h1;
  logic req_valid_i = 1'h0;
  fpc_pkg::fpc_op_t req_op_i = fpc_pkg::OP_READ_ID;
  logic boot_top_i = 1'h0;
  logic pe_busy = 1'h0;
  logic sw_busy = 1'h0;
  logic ready, rsp_valid, sleep, standby, inhibit, write_enable_latch, cmd_valid;
  logic [7:0] status, cmd_code;
  logic [31:0] rsp;
  int mismatches = 0;
  int n_tests = 0;
  fpc_link_if link();
  fpc_host #(.SELECT_CYC(20)) fpc_host_inst (.link(link), .clock_i(clock_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_ready_o(ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp));
  fpc_device #(.WRITE_INHIBIT_CYC(INHIBIT)) fpc_device_inst (.link(link), .clock_i(clock_i), .rst_n_i(rst_n_i),
    .boot_top_i(boot_top_i), .prog_erase_busy_i(pe_busy), .status_write_busy_i(sw_busy), .deep_sleep_o(sleep),
    .standby_o(standby), .write_inhibit_o(inhibit), .write_enable_latch_o(write_enable_latch), .status_o(status),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code));
  fpc_props fpc_props_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n), .miso_line(link.miso_line));
  always #25 clock_i = ~clock_i;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic timed_out(input string what);
    mismatches++;
    $display("MISMATCH %s expected done seen timeout", what);
    close_out();
  endtask
  // The host keeps select high past every device delay, so its ready means the device has settled.
  task automatic settle();
    int i;
    i = 0;
    while (ready !== 1'h1) begin
      if (i == 3000) timed_out("ready");
      @(negedge clock_i);
      i++;
    end
    repeat (10) @(negedge clock_i);
  endtask
  task automatic run_op(input fpc_pkg::fpc_op_t op);
    int i;
    settle();
    req_op_i = op;
    req_valid_i = 1'h1;
    @(negedge clock_i);
    req_valid_i = 1'h0;
    i = 0;
    while (rsp_valid !== 1'h1) begin
      if (i == 1000) timed_out("response");
      @(negedge clock_i);
      i++;
    end
  endtask
  function automatic logic [31:0] id_word(input logic top);
    return {fpc_pkg::ID_CONTINUATION, fpc_pkg::ID_MAKER, fpc_pkg::ID_MEM_TYPE,
      top ? fpc_pkg::ID_CAP_TOP : fpc_pkg::ID_CAP_BOTTOM};
  endfunction
  // ==========
  // Scenarios
  task automatic t_power_up();
    check("sleep", sleep, 1'h0);
    check("standby", standby, 1'h0);
    check("inhibit", inhibit, 1'h1);
    check("latch", write_enable_latch, 1'h0);
    check("status", status, 8'h00);
    check("cycle valid", cmd_valid, 1'h0);
    check("cycle code", cmd_code, 8'h00);
    rst_n_i = 1'h1;
    repeat (INHIBIT - 2) @(negedge clock_i);
    check("inhibit", inhibit, 1'h1);
    repeat (5) @(negedge clock_i);
    check("inhibit", inhibit, 1'h0);
    check("standby", standby, 1'h1);
    $display("test power_up done");
  endtask
  task automatic t_awake_reads();
    for (int b = 0; b < 2; b++) begin
      boot_top_i = b[0];
      run_op(fpc_pkg::OP_READ_ID);
      check("identity", rsp, id_word(b[0]));
    end
    run_op(fpc_pkg::OP_WAKE_SIG);
    check("signature", rsp[7:0], fpc_pkg::SIGNATURE);
    settle();
    check("sleep", sleep, 1'h0);
    check("standby", standby, 1'h1);
    $display("test awake_reads done");
  endtask
  task automatic t_sleep();
    run_op(fpc_pkg::OP_DEEP_SLEEP);
    repeat (30) @(negedge clock_i);
    check("sleep", sleep, 1'h0);
    settle();
    check("sleep", sleep, 1'h1);
    check("standby", standby, 1'h0);
    run_op(fpc_pkg::OP_READ_ID);
    check("identity", rsp, 32'hFFFFFFFF);
    run_op(fpc_pkg::OP_WAKE_SIG);
    check("signature", rsp[7:0], fpc_pkg::SIGNATURE);
    repeat (20) @(negedge clock_i);
    check("sleep", sleep, 1'h1);
    settle();
    check("sleep", sleep, 1'h0);
    $display("test sleep done");
  endtask
  task automatic t_busy();
    pe_busy = 1'h1;
    repeat (3) @(negedge clock_i);
    check("busy flag", status[0], 1'h1);
    check("standby", standby, 1'h0);
    run_op(fpc_pkg::OP_READ_ID);
    check("identity", rsp, 32'hFFFFFFFF);
    run_op(fpc_pkg::OP_WAKE_SIG);
    check("signature", rsp[7:0], 8'hFF);
    run_op(fpc_pkg::OP_DEEP_SLEEP);
    settle();
    check("sleep", sleep, 1'h0);
    pe_busy = 1'h0;
    sw_busy = 1'h1;
    run_op(fpc_pkg::OP_READ_ID);
    check("identity", rsp, id_word(boot_top_i));
    run_op(fpc_pkg::OP_WAKE_SIG);
    check("signature", rsp[7:0], 8'hFF);
    sw_busy = 1'h0;
    repeat (3) @(negedge clock_i);
    check("status", status, 8'h00);
    $display("test busy done");
  endtask
  // A supply loss in deep sleep must bring the device back awake, with the write gate closed again.
  task automatic t_power_loss();
    run_op(fpc_pkg::OP_DEEP_SLEEP);
    settle();
    check("sleep", sleep, 1'h1);
    rst_n_i = 1'h0;
    @(negedge clock_i);
    check("sleep", sleep, 1'h0);
    check("inhibit", inhibit, 1'h1);
    rst_n_i = 1'h1;
    repeat (8) @(negedge clock_i);
    check("standby", standby, 1'h1);
    check("latch", write_enable_latch, 1'h0);
    check("inhibit", inhibit, 1'h1);
    run_op(fpc_pkg::OP_READ_ID);
    check("identity", rsp, id_word(boot_top_i));
    $display("test power_loss done");
  endtask
  initial begin
    #1 rst_n_i = 1'h0;
    repeat (3) @(negedge clock_i);
    t_power_up();
    t_awake_reads();
    t_sleep();
    t_busy();
    t_power_loss();
    close_out();
  end
endmodule
`default_nettype wire
